// ### vps_cfg.svh
/*
 * vps_cfg.svh: register offsets, field positions, bus answer codes and
 * synchroniser depth for the video pattern source.
 * Assumes inclusion by bare name from the core module and the test bench.
 */
`ifndef VPS_CFG_SVH
`define VPS_CFG_SVH

// register byte offsets on the control bus
`define VPS_OFF_DIM     8'h20
`define VPS_OFF_PAT     8'h24
`define VPS_OFF_STAT    8'h28

// field positions inside the frame dimension register
`define VPS_HSIZE_LSB   0
`define VPS_VSIZE_LSB   16
`define VPS_SIZE_W      16

// field position of the pattern selection
`define VPS_PAT_LSB     0

// bus answer codes
`define VPS_RESP_OKAY   2'b00
`define VPS_RESP_SLVERR 2'b10

// number of staging flops between register file and pixel logic
`define VPS_SYNC_STAGES 2

`endif

// ### vps_pkg.sv
/*
 * vps_pkg.sv: types shared by the video pattern source.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vps_pkg;

	// pattern selection codes as held in the pattern register
	typedef enum logic [1:0] {
		PAT_PASS = 2'h0,  // forward the input stream
		PAT_RAMP = 2'h1,  // horizontal ramp on every RGB component, on luma alone in YCbCr
		PAT_BARS = 2'h2,  // eight colour bars, 64 pixels wide, in RGB; two-level luma bars in YCbCr
		PAT_FLAT = 2'h3   // full-scale flat field
	} vps_pattern_e;

	// parallel status indications, one-cycle pulses
	typedef struct packed {
		logic frameDone;  // last beat of a frame loaded into the output register
		logic sofEarly;   // start-of-frame seen inside a frame
		logic eolEarly;   // end-of-line before the line was complete
		logic eolLate;    // line complete without end-of-line
	} vps_status_s;

endpackage

// ### vps_pattern_source.sv
/*
 * vps_pattern_source.sv: video pattern source with optional control
 * registers, optional video input and optional status port.
 * Assumes one clock core_clk with synchronous active-high rst; the
 * register bus master and both stream partners run on that clock.
 */
`timescale 1ns/1ps
`include "vps_cfg.svh"

// Summary of operation
// R1: horizontal size resets to generation default
// R2: vertical size resets to generation default
// R3: without registers, frame size stays fixed
// R4: maximum line length limited to 32..7680
// R5: software keeps line length below maximum
// R6: sample width is 8, 10 or 12
// R7: colour format fixed at generation time
// R8: default pattern after reset, register changes it
// R9: without registers, default pattern forever
// R10: without registers, no video input port
// R11: input enabled needs video, else generate
// R12: pass-through without input gives black/green
// R13: optional status port shows frame and errors
// R14: register values synchronised into pixel logic
// R15: bus clock at most 128 times pixel
// R16: bus clock within pixel clock maximum
// R17: config passes staging flops before use
module vps_pattern_source #(
	parameter int HAS_REGS   = 1,     // control registers built in
	parameter int HAS_VIN    = 1,     // video input stream built in
	parameter int HAS_STATUS = 1,     // status port driven
	parameter int FMT_YUV    = 0,     // 0 RGB, 1 YCbCr 4:2:2
	parameter int DW         = 8,     // bits per component sample
	parameter int MAX_W      = 1920,  // longest line in pixels
	parameter int DEF_H      = 1280,  // default pixels per line
	parameter int DEF_V      = 720,   // default lines per frame
	parameter int DEF_PAT    = 1      // default pattern code
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [3*DW-1:0]       s_axis_video_tdata,
	input  wire logic                  s_axis_video_tvalid,
	output logic                       s_axis_video_tready,
	input  wire logic                  s_axis_video_tuser,
	input  wire logic                  s_axis_video_tlast,
	output logic [3*DW-1:0]            m_axis_video_tdata,
	output logic                       m_axis_video_tvalid,
	input  wire logic                  m_axis_video_tready,
	output logic                       m_axis_video_tuser,
	output logic                       m_axis_video_tlast,
	output vps_pkg::vps_status_s       status_flag_port
);

	localparam int TW  = 3 * DW;                          // stream word width
	localparam int VIN = int'(HAS_REGS != 0 && HAS_VIN != 0); // input only with registers R10
	localparam logic [31:0] DIM_RST = {16'(DEF_V), 16'(DEF_H)};

	// refuse parameter values the logic cannot serve
	if (MAX_W < 32 || MAX_W > 7680) begin : g_chk_max // R4
		$error("maximum line length out of range");
	end
	if (DW != 8 && DW != 10 && DW != 12) begin : g_chk_dw // R6
		$error("sample width must be 8, 10 or 12");
	end
	if (DEF_H < 1 || DEF_H > MAX_W || DEF_V < 1 || DEF_V > 65535) begin : g_chk_def
		$error("default frame size out of range");
	end
	if (DEF_PAT < 0 || DEF_PAT > 3 || FMT_YUV < 0 || FMT_YUV > 1) begin : g_chk_pat
		$error("default pattern or format code illegal");
	end

	// merge a written word into a register under the byte strobes
	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
	                                           input logic [31:0] wr,
	                                           input logic [3:0]  strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = wr[8*i +: 8];
			end
		end
		return res;
	endfunction

	// last pixel or line index for a programmed size, guarded against zero and overrun
	function automatic logic [15:0] lastIdx(input logic [15:0] sz, input logic [15:0] cap);
		logic [15:0] lim;
		lim = (sz > cap) ? cap : sz;
		return (lim == 16'h0) ? 16'h0 : lim - 16'h1;
	endfunction

	// register-bus state
	logic        awRdy_q, awRdy_d;   // write address and data taken together
	logic        bVal_q, bVal_d;     // write answer pending
	logic [1:0]  bResp_q, bResp_d;   // write answer code
	logic        arRdy_q, arRdy_d;   // read address taken
	logic        rVal_q, rVal_d;     // read answer pending
	logic [31:0] rData_q, rData_d;   // read answer word
	logic [1:0]  rResp_q, rResp_d;   // read answer code
	logic [31:0] dim_q, dim_d;       // frame dimension register
	vps_pkg::vps_pattern_e pat_q, pat_d; // pattern selection register

	// pixel-side state
	logic [31:0] dimS_q [`VPS_SYNC_STAGES];  // staged frame dimension
	vps_pkg::vps_pattern_e patS_q [`VPS_SYNC_STAGES]; // staged pattern
	logic [15:0] hLast_q, hLast_d;   // last pixel index of current frame
	logic [15:0] vLast_q, vLast_d;   // last line index of current frame
	vps_pkg::vps_pattern_e curPat_q, curPat_d; // pattern of current frame
	logic [15:0] x_q, x_d;           // pixel position in line
	logic [15:0] y_q, y_d;           // line position in frame
	logic          oVal_q, oVal_d;   // output beat held
	logic [TW-1:0] oData_q, oData_d; // output sample word
	logic          oUser_q, oUser_d; // output start of frame
	logic          oLast_q, oLast_d; // output end of line
	logic          sRdy_q, sRdy_d;   // input stream ready
	vps_pkg::vps_status_s stat_q, stat_d; // status pulses

	// combinational helpers
	logic        frameStart;         // next beat is pixel 0 of line 0
	logic [15:0] hL, vL;             // limits that apply to the next beat
	vps_pkg::vps_pattern_e effPat;   // pattern that applies to the next beat
	logic        take;               // input beat accepted this cycle
	logic [TW-1:0] genPix;           // generated sample word

	// register file and bus answers; writes take address and data together
	always_comb begin
		awRdy_d = awRdy_q;
		bVal_d  = bVal_q;
		bResp_d = bResp_q;
		arRdy_d = arRdy_q;
		rVal_d  = rVal_q;
		rData_d = rData_q;
		rResp_d = rResp_q;
		dim_d   = dim_q;
		pat_d   = pat_q;
		if (HAS_REGS != 0) begin
			if (awRdy_q) begin
				// handshake completes now; address and data are stable
				awRdy_d = 1'b0;
				bVal_d  = 1'b1;
				bResp_d = `VPS_RESP_OKAY;
				case (s_axi_awaddr)
					`VPS_OFF_DIM: dim_d = mergeBytes(dim_q, s_axi_wdata, s_axi_wstrb);
					`VPS_OFF_PAT: begin
						if (s_axi_wstrb[0]) begin
							pat_d = vps_pkg::vps_pattern_e'(s_axi_wdata[`VPS_PAT_LSB +: 2]); // R8
						end
					end
					`VPS_OFF_STAT: ; // read-only, write ignored
					default: bResp_d = `VPS_RESP_SLVERR;
				endcase
			end else if (bVal_q) begin
				if (s_axi_bready) begin
					bVal_d = 1'b0;
				end
			end else if (s_axi_awvalid && s_axi_wvalid) begin
				awRdy_d = 1'b1;
			end
			if (arRdy_q) begin
				arRdy_d = 1'b0;
				rVal_d  = 1'b1;
				rResp_d = `VPS_RESP_OKAY;
				case (s_axi_araddr)
					`VPS_OFF_DIM:  rData_d = dim_q;
					`VPS_OFF_PAT:  rData_d = {30'h0, pat_q};
					`VPS_OFF_STAT: rData_d = {y_q, 14'h0, curPat_q};
					default: begin
						rData_d = 32'h0;
						rResp_d = `VPS_RESP_SLVERR;
					end
				endcase
			end else if (rVal_q) begin
				if (s_axi_rready) begin
					rVal_d = 1'b0;
				end
			end else if (s_axi_arvalid) begin
				arRdy_d = 1'b1;
			end
		end
	end

	// register-bus flops; without registers dim and pattern never leave defaults
	always_ff @(posedge core_clk) begin
		if (rst) begin
			awRdy_q <= 1'b0;
			bVal_q  <= 1'b0;
			bResp_q <= `VPS_RESP_OKAY;
			arRdy_q <= 1'b0;
			rVal_q  <= 1'b0;
			rData_q <= 32'h0;
			rResp_q <= `VPS_RESP_OKAY;
			dim_q   <= DIM_RST;  // R1 R2 R3
			pat_q   <= vps_pkg::vps_pattern_e'(DEF_PAT[1:0]); // R8 R9
		end else begin
			awRdy_q <= awRdy_d;
			bVal_q  <= bVal_d;
			bResp_q <= bResp_d;
			arRdy_q <= arRdy_d;
			rVal_q  <= rVal_d;
			rData_q <= rData_d;
			rResp_q <= rResp_d;
			dim_q   <= dim_d;
			pat_q   <= pat_d;
		end
	end

	// generated samples; the sample word layout is fixed by the format R7
	always_comb begin
		logic [2:0]    bar;
		logic [DW-1:0] r, g, b;
		bar = x_q[8:6];
		r = '0;
		g = '0;
		b = '0;
		unique case (effPat)
			vps_pkg::PAT_RAMP: begin
				r = x_q[DW-1:0];
				g = x_q[DW-1:0];
				b = x_q[DW-1:0];
			end
			vps_pkg::PAT_BARS: begin
				r = {DW{bar[2]}};
				g = {DW{bar[1]}};
				b = {DW{bar[0]}};
			end
			vps_pkg::PAT_FLAT: begin
				r = '1;
				g = '1;
				b = '1;
			end
			vps_pkg::PAT_PASS: ; // no input: zero words, black or green R12
		endcase
		if (FMT_YUV != 0) begin
			// luma from green, chroma mid-scale except in pass-through
			genPix = {{DW{1'b0}}, (effPat == vps_pkg::PAT_PASS) ? {DW{1'b0}} :
			          {1'b1, {(DW-1){1'b0}}}, g};
		end else begin
			genPix = {r, b, g};
		end
	end

	// pixel stream: staging, frame counters, beat selection and status
	always_comb begin
		frameStart = (x_q == 16'h0) && (y_q == 16'h0);
		hL = frameStart ? lastIdx(dimS_q[`VPS_SYNC_STAGES-1][`VPS_HSIZE_LSB +: `VPS_SIZE_W],
		                          16'(MAX_W)) : hLast_q; // R5
		vL = frameStart ? lastIdx(dimS_q[`VPS_SYNC_STAGES-1][`VPS_VSIZE_LSB +: `VPS_SIZE_W],
		                          16'hffff) : vLast_q;
		effPat = frameStart ? patS_q[`VPS_SYNC_STAGES-1] : curPat_q; // R17
		take = sRdy_q && s_axis_video_tvalid;
		hLast_d  = hLast_q;
		vLast_d  = vLast_q;
		curPat_d = curPat_q;
		x_d      = x_q;
		y_d      = y_q;
		oVal_d   = oVal_q;
		oData_d  = oData_q;
		oUser_d  = oUser_q;
		oLast_d  = oLast_q;
		stat_d   = '0;
		if (oVal_q && m_axis_video_tready) begin
			oVal_d = 1'b0;
		end
		if (take) begin
			// pass-through beat; input ready only rises with the output empty R11
			oVal_d  = 1'b1;
			oData_d = s_axis_video_tdata;
			oUser_d = s_axis_video_tuser;
			oLast_d = s_axis_video_tlast;
			stat_d.sofEarly = s_axis_video_tuser && !frameStart;                // R13
			stat_d.eolEarly = s_axis_video_tlast && (x_q != hL);
			stat_d.eolLate  = !s_axis_video_tlast && (x_q == hL);
		end else if ((effPat != vps_pkg::PAT_PASS || VIN == 0) &&
		             (!oVal_q || m_axis_video_tready)) begin
			oVal_d  = 1'b1; // R11 R12
			oData_d = genPix;
			oUser_d = frameStart;
			oLast_d = (x_q == hL);
		end
		if (oVal_d && !(oVal_q && !m_axis_video_tready) && (take || !oVal_q ||
		    m_axis_video_tready)) begin
			// a new beat was loaded: advance the raster position
			if (frameStart) begin
				hLast_d  = hL;
				vLast_d  = vL;
				curPat_d = effPat;
			end
			x_d = (x_q == hL) ? 16'h0 : x_q + 16'h1;
			if (x_q == hL) begin
				y_d = (y_q == vL) ? 16'h0 : y_q + 16'h1;
				stat_d.frameDone = (y_q == vL); // R13
			end
		end
		// input held ready only while pass-through and the output is free R10 R11
		sRdy_d = (VIN != 0) && (effPat == vps_pkg::PAT_PASS) && !oVal_d;
		if (HAS_STATUS == 0) begin
			stat_d = '0;
		end
	end

	// pixel flops; config is re-registered before use R14 R17
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < `VPS_SYNC_STAGES; i++) begin
				dimS_q[i] <= DIM_RST;
				patS_q[i] <= vps_pkg::vps_pattern_e'(DEF_PAT[1:0]);
			end
			hLast_q  <= 16'h0;
			vLast_q  <= 16'h0;
			curPat_q <= vps_pkg::vps_pattern_e'(DEF_PAT[1:0]);
			x_q      <= 16'h0;
			y_q      <= 16'h0;
			oVal_q   <= 1'b0;
			oData_q  <= '0;
			oUser_q  <= 1'b0;
			oLast_q  <= 1'b0;
			sRdy_q   <= 1'b0;
			stat_q   <= '0;
		end else begin
			dimS_q[0] <= dim_q;
			patS_q[0] <= pat_q;
			for (int i = 1; i < `VPS_SYNC_STAGES; i++) begin
				dimS_q[i] <= dimS_q[i-1];
				patS_q[i] <= patS_q[i-1];
			end
			hLast_q  <= hLast_d;
			vLast_q  <= vLast_d;
			curPat_q <= curPat_d;
			x_q      <= x_d;
			y_q      <= y_d;
			oVal_q   <= oVal_d;
			oData_q  <= oData_d;
			oUser_q  <= oUser_d;
			oLast_q  <= oLast_d;
			sRdy_q   <= sRdy_d;
			stat_q   <= stat_d;
		end
	end

	assign s_axi_awready       = awRdy_q;
	assign s_axi_wready        = awRdy_q;
	assign s_axi_bvalid        = bVal_q;
	assign s_axi_bresp         = bResp_q;
	assign s_axi_arready       = arRdy_q;
	assign s_axi_rvalid        = rVal_q;
	assign s_axi_rdata         = rData_q;
	assign s_axi_rresp         = rResp_q;
	assign s_axis_video_tready = sRdy_q;
	assign m_axis_video_tvalid = oVal_q;
	assign m_axis_video_tdata  = oData_q;
	assign m_axis_video_tuser  = oUser_q;
	assign m_axis_video_tlast  = oLast_q;
	assign status_flag_port    = stat_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// reset loads the horizontal default
	property p_rst_hsize;
		@(posedge core_clk) disable iff (1'b0)
		rst |=> dim_q[15:0] == 16'(DEF_H);
	endproperty
	a_rst_hsize: assert property (p_rst_hsize) else $error("hsize reset wrong"); // R1

	// reset loads the vertical default
	property p_rst_vsize;
		@(posedge core_clk) disable iff (1'b0)
		rst |=> dim_q[31:16] == 16'(DEF_V);
	endproperty
	a_rst_vsize: assert property (p_rst_vsize) else $error("vsize reset wrong"); // R2

	// without registers the size and pattern never move
	property p_fixed_cfg;
		(HAS_REGS == 0) |-> (dim_q == DIM_RST && pat_q == vps_pkg::vps_pattern_e'(DEF_PAT[1:0]));
	endproperty
	a_fixed_cfg: assert property (p_fixed_cfg) else $error("fixed config moved"); // R3

	// a pattern write reaches the end of staging two cycles later
	sequence s_pat_write;
		awRdy_q && s_axi_awaddr == `VPS_OFF_PAT && s_axi_wstrb[0];
	endsequence
	property p_pat_stage;
		s_pat_write ##1 1'b1 |-> ##2 patS_q[`VPS_SYNC_STAGES-1] == $past(pat_q, 2);
	endproperty
	a_pat_stage: assert property (p_pat_stage) else $error("pattern not staged"); // R17

	// no input port is ever ready without the input built in
	property p_no_vin;
		(VIN == 0) |-> !s_axis_video_tready;
	endproperty
	a_no_vin: assert property (p_no_vin) else $error("input ready without port"); // R10

	// pass-through output only follows an accepted input beat
	property p_pass_src;
		(VIN != 0 && curPat_q == vps_pkg::PAT_PASS && !frameStart && $rose(m_axis_video_tvalid))
		|-> $past(take);
	endproperty
	a_pass_src: assert property (p_pass_src) else $error("pass beat without input"); // R11

	// pass-through with no input gives zero words
	property p_pass_zero;
		(VIN == 0 && curPat_q == vps_pkg::PAT_PASS && m_axis_video_tvalid && !m_axis_video_tuser)
		|-> m_axis_video_tdata == '0;
	endproperty
	a_pass_zero: assert property (p_pass_zero) else $error("pass without input not blank"); // R12

	// frame done pulses for one cycle after the final raster position
	property p_frame_done;
		(HAS_STATUS != 0 && frameStart && $past(x_q) == $past(hLast_q) && $past(y_q) != 16'h0)
		|-> status_flag_port.frameDone ##1 !status_flag_port.frameDone;
	endproperty
	a_frame_done: assert property (p_frame_done) else $error("frame done missing"); // R13

endmodule

// ### vps_stream_partner.sv
/*
 * vps_stream_partner.sv: upstream video source feeding the pattern source input.
 * Assumes go is raised for one clock by the bench, with hSize, vSize and base held.
 */
`timescale 1ns/1ps
module vps_stream_partner #(
	parameter int DW = 8  // bits per component sample
) (
	input  wire logic            core_clk,
	input  wire logic            go,
	input  wire logic [3*DW-1:0] base,
	input  wire logic [15:0]     hSize,
	input  wire logic [15:0]     vSize,
	output logic      [3*DW-1:0] tdata,
	output logic                 tvalid,
	input  wire logic            tready,
	output logic                 tuser,
	output logic                 tlast
);
	int   idx;    // beat index inside the frame
	logic taken;  // beat accepted at the last rising edge
	logic start;  // go seen at the last rising edge

	initial begin
		idx = 0;
		taken = 1'b0;
		start = 1'b0;
		tvalid = 1'b0;
		tdata = '0;
		tuser = 1'b0;
		tlast = 1'b0;
	end

	// sample handshakes on the edge, act on them half a cycle later
	always @(posedge core_clk) begin
		taken <= tvalid & tready;
		start <= go;
	end

	// hold each beat until taken; one whole frame per go
	always @(negedge core_clk) begin
		if (start) begin
			idx = 0;
			tvalid = 1'b1;
		end else if (tvalid && taken) begin
			idx = idx + 1;
			if (idx == hSize * vSize) begin
				tvalid = 1'b0;
			end
		end
		if (tvalid) begin
			tdata = base + (3*DW)'(idx);
			tuser = (idx == 0);
			tlast = (idx % hSize == hSize - 1);
		end else begin
			// released lines toggle so a stale word never looks valid
			tdata = ~tdata;
			tuser = ~tuser;
			tlast = ~tlast;
		end
	end
endmodule

// ### vps_pattern_source_test.sv
/*
 * vps_pattern_source_test.sv: self-checking bench for the video pattern source.
 * Assumes bus and pixel logic share one 40 MHz clock and the partner source.
 */
`timescale 1ns/1ps
`include "vps_cfg.svh"
module vps_pattern_source_test;
	localparam int DW = 8;      // sample width under test
	localparam int DEF_H = 16;  // small default frame keeps the run short
	localparam int DEF_V = 4;
	localparam int MAX_W = 64;  // short maximum line length, still above every programmed length

	// one expected output beat
	typedef struct packed {
		logic            chkData;
		logic [3*DW-1:0] data;
		logic            user;
		logic            last;
	} vps_beat_s;

	logic core_clk, rst, awValid, wValid, bReady, arValid, rReady;
	logic [7:0] awAddr, arAddr;
	logic [31:0] wData, rData;
	logic [3:0] wStrb;             // write byte strobes
	logic awReady, wReady, bValid, arReady, rValid, go;
	logic [1:0] bResp, rResp;
	logic [3*DW-1:0] sData, mData, base;
	logic sValid, sReady, sUser, sLast, mValid, mReady, mUser, mLast;
	logic [15:0] hSize, vSize;
	vps_pkg::vps_status_s status;  // status pulses
	vps_beat_s oq[$];              // expected stream beats
	vps_beat_s oE;
	logic [33:0] rq[$];            // expected bus answers {resp, data}
	logic [33:0] rE;
	int err_count, checked;
	integer seed = 32'hceef7208;

	vps_pattern_source #(.HAS_REGS(1), .HAS_VIN(1), .HAS_STATUS(1), .FMT_YUV(0), .DW(DW),
		.MAX_W(MAX_W), .DEF_H(DEF_H), .DEF_V(DEF_V), .DEF_PAT(1)) DUT (
		.core_clk(core_clk), .rst(rst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.s_axis_video_tdata(sData), .s_axis_video_tvalid(sValid),
		.s_axis_video_tready(sReady), .s_axis_video_tuser(sUser),
		.s_axis_video_tlast(sLast), .m_axis_video_tdata(mData),
		.m_axis_video_tvalid(mValid), .m_axis_video_tready(mReady),
		.m_axis_video_tuser(mUser), .m_axis_video_tlast(mLast),
		.status_flag_port(status));

	vps_stream_partner #(.DW(DW)) SRC (.core_clk(core_clk), .go(go), .base(base),
		.hSize(hSize), .vSize(vSize), .tdata(sData), .tvalid(sValid), .tready(sReady),
		.tuser(sUser), .tlast(sLast));

	always #12.5 core_clk = ~core_clk;

	// sink throttles at random so held output beats get exercised
	always @(negedge core_clk) begin
		mReady = 1'($random(seed));
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// write: hold address and data until the ready edge, then await the answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
	                  input logic [1:0] resp);
		int n;
		rq.push_back({resp, 32'h0});
		@(negedge core_clk);
		awAddr = a;
		wData = d;
		wStrb = s;
		awValid = 1'b1;
		wValid = 1'b1;
		n = 0;
		do @(posedge core_clk); while (awReady !== 1'b1 && ++n < 50);
		@(negedge core_clk);
		awValid = 1'b0;
		wValid = 1'b0;
		bReady = 1'b1;
		do @(posedge core_clk); while (bValid !== 1'b1 && ++n < 100);
		@(negedge core_clk);
		bReady = 1'b0;
		chk("write wait", 32'(n < 100), 32'h1);
	endtask

	// read: the monitor compares data and answer code
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		int n;
		rq.push_back({resp, d});
		@(negedge core_clk);
		arAddr = a;
		arValid = 1'b1;
		n = 0;
		do @(posedge core_clk); while (arReady !== 1'b1 && ++n < 50);
		@(negedge core_clk);
		arValid = 1'b0;
		rReady = 1'b1;
		do @(posedge core_clk); while (rValid !== 1'b1 && ++n < 100);
		@(negedge core_clk);
		rReady = 1'b0;
		chk("read wait", 32'(n < 100), 32'h1);
	endtask

	// expect one whole frame starting after the next frame end
	task automatic frame(input int h, input int v, input logic cd, input logic pass);
		int n;
		n = 0;
		repeat (4) @(negedge core_clk);  // staged settings need two cycles
		while (status.frameDone !== 1'b1 && n++ < 2000) @(negedge core_clk);
		chk("frame sync", 32'(status.frameDone), 32'h1);
		// the beat loaded with the frame-done pulse still waits in the output register
		oq.push_back('{chkData: 1'b0, data: '0, user: 1'b0, last: 1'b1});
		hSize = 16'(h);
		vSize = 16'(v);
		for (int k = 0; k < h * v; k++) begin
			oq.push_back('{chkData: cd, data: pass ? base + (3*DW)'(k) : base,
				user: (k == 0), last: (k % h == h - 1)});
		end
		go = pass;
		@(negedge core_clk);
		go = 1'b0;
		n = 0;
		while (oq.size() > 0 && n++ < 3000) @(negedge core_clk);
		chk("beats left", 32'(oq.size()), 32'h0);
	endtask

	// compare results against the oldest note as they appear
	always @(posedge core_clk) begin
		if (!rst && bValid && bReady && rq.size() > 0) begin
			rE = rq.pop_front();
			chk("write resp", 32'(bResp), 32'(rE[33:32]));
		end
		if (!rst && rValid && rReady && rq.size() > 0) begin
			rE = rq.pop_front();
			chk("read data", rData, rE[31:0]);
			chk("read resp", 32'(rResp), 32'(rE[33:32]));
		end
		if (!rst && mValid && mReady && oq.size() > 0) begin
			oE = oq.pop_front();
			chk("tuser", 32'(mUser), 32'(oE.user));
			chk("tlast", 32'(mLast), 32'(oE.last));
			if (oE.chkData) begin
				chk("tdata", 32'(mData), 32'(oE.data));
			end
		end
		// well-formed input frames and generated frames never raise an error pulse
		if (!rst && {status.sofEarly, status.eolEarly, status.eolLate} !== 3'h0) begin
			chk("status errors", 32'({status.sofEarly, status.eolEarly, status.eolLate}),
			    32'h0);
		end
	end

	// cut a hang short
	initial begin
		#1000000;
		err_count++;
		stop_test();
	end

	initial begin
		logic [1:0] p;
		core_clk = 1'b0;
		rst = 1'b1;
		{awValid, wValid, bReady, arValid, rReady, go} = '0;
		{awAddr, arAddr, wData} = '0;
		wStrb = '0;
		base = '0;
		hSize = 16'(DEF_H);
		vSize = 16'(DEF_V);
		mReady = 1'b1;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		rd(`VPS_OFF_DIM, {16'(DEF_V), 16'(DEF_H)}, `VPS_RESP_OKAY);
		rd(`VPS_OFF_PAT, 32'h1, `VPS_RESP_OKAY);
		rd(8'h30, 32'h0, `VPS_RESP_SLVERR);
		wr(8'h30, 32'hffff_ffff, 4'hf, `VPS_RESP_SLVERR);
		frame(DEF_H, DEF_V, 1'b0, 1'b0);
		$display("test reset and default frame done");
		// line length stays below the maximum of 64
		wr(`VPS_OFF_DIM, {16'h3, 16'h8}, 4'hf, `VPS_RESP_OKAY);
		rd(`VPS_OFF_DIM, {16'h3, 16'h8}, `VPS_RESP_OKAY);
		// strobes merge bytes; a pattern write without byte 0 is dropped
		wr(`VPS_OFF_DIM, 32'h0003_ffff, 4'hc, `VPS_RESP_OKAY);
		rd(`VPS_OFF_DIM, {16'h3, 16'h8}, `VPS_RESP_OKAY);
		wr(`VPS_OFF_PAT, 32'h2, 4'he, `VPS_RESP_OKAY);
		rd(`VPS_OFF_PAT, 32'h1, `VPS_RESP_OKAY);
		$display("test register strobes done");
		// ramp, bars, flat, then pass last since it waits for input
		for (int i = 0; i < 4; i++) begin
			p = 2'(i + 1);
			wr(`VPS_OFF_PAT, {30'h0, p}, 4'($random(seed)) | 4'h1, `VPS_RESP_OKAY);
			rd(`VPS_OFF_PAT, {30'h0, p}, `VPS_RESP_OKAY);
			base = (p == 2'h3) ? '1 : (3*DW)'($random(seed));
			frame(8, 3, p == 2'h3 || p == 2'h0, p == 2'h0);
			$display("test pattern %0d done", p);
		end
		stop_test();
	end
endmodule
